// ### snw_pkg.sv
// constants and types shared by the status register and write guard block
// assumes an spi host in mode 0 or 3 and a save/restore engine on the system clock
package snw_pkg;

    // memory address width and protected range starts
    localparam int unsigned  SNW_ADDR_W    = 13;
    localparam logic [12:0]  SNW_QTR_BASE  = 13'h1800;
    localparam logic [12:0]  SNW_HALF_BASE = 13'h1000;
    localparam logic [12:0]  SNW_ADDR_ONE  = 13'h0001;

    // protect levels
    localparam logic [1:0]   SNW_LVL_NONE  = 2'h0;
    localparam logic [1:0]   SNW_LVL_QTR   = 2'h1;
    localparam logic [1:0]   SNW_LVL_HALF  = 2'h2;
    localparam logic [1:0]   SNW_LVL_ALL   = 2'h3;

    // status register bit positions
    localparam int unsigned  SNW_ST_RDY    = 0;
    localparam int unsigned  SNW_ST_WEN    = 1;
    localparam int unsigned  SNW_ST_LVL_LO = 2;
    localparam int unsigned  SNW_ST_LVL_HI = 3;
    localparam int unsigned  SNW_ST_LOCK   = 6;
    localparam int unsigned  SNW_ST_PGEN   = 7;

    // status reset value and the bits a status write may touch
    localparam logic [7:0]   SNW_ST_RST    = 8'h00;
    localparam logic [7:0]   SNW_ST_WMASK  = 8'hCC;

    // instruction codes
    localparam logic [7:0]   SNW_OP_RDSTAT = 8'h05;
    localparam logic [7:0]   SNW_OP_FRDST  = 8'h09;
    localparam logic [7:0]   SNW_OP_WRSTAT = 8'h01;
    localparam logic [7:0]   SNW_OP_WRITE_ENABLE_CMD   = 8'h06;
    localparam logic [7:0]   SNW_OP_WRDIS  = 8'h04;
    localparam logic [7:0]   SNW_OP_MEMWR  = 8'h02;
    localparam logic [7:0]   SNW_OP_CLKWR  = 8'h12;
    localparam logic [7:0]   SNW_OP_SAVE   = 8'h3C;
    localparam logic [7:0]   SNW_OP_RESTR  = 8'h60;
    localparam logic [7:0]   SNW_OP_ASON   = 8'h59;
    localparam logic [7:0]   SNW_OP_ASOFF  = 8'h19;
    localparam logic [7:0]   SNW_OP_SERWR  = 8'hC2;

    // byte positions within a frame
    localparam logic [1:0]   SNW_IDX_OPC   = 2'h0;
    localparam logic [1:0]   SNW_IDX_B1    = 2'h1;
    localparam logic [1:0]   SNW_IDX_B2    = 2'h2;
    localparam logic [1:0]   SNW_IDX_DATA  = 2'h3;
    localparam logic [2:0]   SNW_BIT_LAST  = 3'h7;
    localparam logic [2:0]   SNW_BIT_FIRST = 3'h0;

    // frame states on the system clock
    typedef enum logic [3:0] {
        SNW_IDLE = 4'h1,
        SNW_OPC  = 4'h2,
        SNW_RUN  = 4'h4,
        SNW_SKIP = 4'h8
    } snw_frm_t;

endpackage

// ### snw_spi_host.sv
// behavioural spi host driving frames into the status and guard block
// assumes mode 0: sck idles low and stands still between frames
`timescale 1ns/10ps
module snw_spi_host (
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i
);
    // idle levels at time zero
    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // nb bytes msb first from the top of tx; rx keeps the last byte seen on so
    task automatic frame(input int nb, input logic [63:0] tx, output logic [7:0] rx);
        logic [63:0] sh;
        sh     = tx;
        rx     = 8'h00;
        cs_n_o = 1'b0;
        #62.5;
        for (int b = 0; b < nb * 8; b++) begin
            si_o = sh[63];
            sh   = sh << 1;
            #62.5 sck_o = 1'b1;
            rx = {rx[6:0], so_i};
            #62.5 sck_o = 1'b0;
        end
        #62.5 cs_n_o = 1'b1;
        si_o = ~si_o; // released data shows no stale value
        #1000;
    endtask
endmodule

// ### snw_status_guard.sv
// status register, write latch and block protection of an spi nonvolatile sram
// assumes sck_i comes from the host and stops between frames; mclk_i runs free
`timescale 1ns/10ps
module snw_status_guard
    import snw_pkg::*;
#(
    parameter int unsigned ADDR_W = SNW_ADDR_W
) (
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire logic              sck_i,
    input  wire logic              cs_n_i,
    input  wire logic              si_i,
    input  wire logic              wp_n_i,
    input  wire logic              nv_busy_i,
    output logic                   so_o,
    output logic                   so_oe_o,
    output logic [7:0]             status_o,
    output logic                   mem_wr_o,
    output logic [ADDR_W-1:0]      mem_addr_o,
    output logic [7:0]             wr_data_o,
    output logic                   serial_wr_o,
    output logic                   clock_wr_o,
    output logic                   save_req_o,
    output logic                   restore_req_o,
    output logic                   autosave_on_o,
    output logic                   autosave_off_o
);

    // the protected ranges are fixed for this array size
    if (ADDR_W != SNW_ADDR_W) begin : g_chk
        $error("snw_status_guard: ADDR_W must equal the array address width");
    end

    // link side frame state, cleared whenever chip select is high
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [7:0] opc;
        logic [6:0] sin;
    } snw_lnk_t;

    // link side state that must survive between frames
    typedef struct packed {
        logic       tog;
        logic [7:0] hold;
        logic [7:0] st_s1;
        logic [7:0] st_s2;
    } snw_lkx_t;

    // serial output, launched on the falling edge
    typedef struct packed {
        logic       so;
        logic       oe;
        logic [6:0] osh;
    } snw_out_t;

    // system clock side
    typedef struct packed {
        logic              cs_s1;
        logic              cs_s2;
        logic              cs_d1;
        logic              cs_d2;
        logic              tg_s1;
        logic              tg_s2;
        logic              tg_d;
        logic              wp_s1;
        logic              wp_s2;
        snw_frm_t          frm;
        logic [1:0]        idx;
        logic [7:0]        opc;
        logic              guard;
        logic [7:0]        st;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] mem_addr;
        logic [7:0]        wdata;
        logic              mem_wr;
        logic              ser_wr;
        logic              clk_wr;
        logic              save;
        logic              restore;
        logic              as_on;
        logic              as_off;
    } snw_sys_t;

    snw_lnk_t lnk_ff;
    snw_lnk_t nxt_lnk;
    snw_lkx_t lkx_ff;
    snw_lkx_t nxt_lkx;
    snw_out_t out_ff;
    snw_out_t nxt_out;
    snw_sys_t sys_ff;
    snw_sys_t nxt_sys;

    logic       frm_rstn;
    logic [7:0] lnk_full;
    logic       lnk_byte;
    logic       rd_phase;
    logic       frame_start;
    logic       frame_end;
    logic       byte_ev;
    logic       addr_prot;

    // write, status write, clock, serial and nonvolatile instructions need the latch
    function automatic logic snw_gated(input logic [7:0] op);
        snw_gated = (op == SNW_OP_WRSTAT) || (op == SNW_OP_MEMWR) ||
                    (op == SNW_OP_CLKWR)  || (op == SNW_OP_SERWR) ||
                    (op == SNW_OP_SAVE)   || (op == SNW_OP_RESTR) ||
                    (op == SNW_OP_ASON)   || (op == SNW_OP_ASOFF);
    endfunction

    // address against the selected protect level
    function automatic logic snw_prot(input logic [ADDR_W-1:0] a, input logic [1:0] lvl);
        case (lvl)
            SNW_LVL_NONE: snw_prot = 1'b0;
            SNW_LVL_QTR:  snw_prot = (a >= SNW_QTR_BASE);
            SNW_LVL_HALF: snw_prot = (a >= SNW_HALF_BASE);
            SNW_LVL_ALL:  snw_prot = 1'b1;
            default:      snw_prot = 1'b1;
        endcase
    endfunction

    // frame reset: constant load only; a glitch on cs_n just restarts an idle frame
    assign frm_rstn = rstn_i & ~cs_n_i;

    // ---------------- link domain (sck_i) ----------------

    // byte assembly, msb first, sampled on the rising edge
    always_comb begin
        nxt_lnk  = lnk_ff;
        lnk_full = {lnk_ff.sin, si_i};
        lnk_byte = (lnk_ff.bit_cnt == SNW_BIT_LAST);
        nxt_lnk.sin     = lnk_full[6:0];
        nxt_lnk.bit_cnt = lnk_ff.bit_cnt + 3'h1;
        if (lnk_byte) begin
            if (lnk_ff.byte_cnt == SNW_IDX_OPC) begin
                nxt_lnk.opc = lnk_full;
            end
            if (lnk_ff.byte_cnt != SNW_IDX_DATA) begin
                nxt_lnk.byte_cnt = lnk_ff.byte_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge sck_i or negedge frm_rstn) begin
        if (!frm_rstn) begin
            lnk_ff <= '0;
        end else begin
            lnk_ff <= nxt_lnk;
        end
    end

    // byte hand-off by toggle; hold stays put for a whole byte time, so the
    // system side may read it once it sees the toggle move
    always_comb begin
        nxt_lkx       = lkx_ff;
        nxt_lkx.st_s1 = sys_ff.st;
        nxt_lkx.st_s2 = lkx_ff.st_s1;
        if (lnk_byte) begin
            nxt_lkx.hold = lnk_full;
            nxt_lkx.tog  = ~lkx_ff.tog;
        end
    end

    // status only changes between frames (ready aside), so the opcode clocks
    // settle the synchroniser before any bit is shifted out
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lkx_ff <= '0;
        end else begin
            lkx_ff <= nxt_lkx;
        end
    end

    // plain read after the opcode, fast read after one dummy byte
    assign rd_phase = ((lnk_ff.opc == SNW_OP_RDSTAT) && (lnk_ff.byte_cnt >= SNW_IDX_B1)) ||
                      ((lnk_ff.opc == SNW_OP_FRDST) && (lnk_ff.byte_cnt >= SNW_IDX_B2));

    // shift out on the falling edge, reloading the current value at each byte
    always_comb begin
        nxt_out    = out_ff;
        nxt_out.oe = rd_phase;
        if (!rd_phase) begin
            nxt_out.so = 1'b0;
        end else if (lnk_ff.bit_cnt == SNW_BIT_FIRST) begin
            nxt_out.so  = lkx_ff.st_s2[7];
            nxt_out.osh = lkx_ff.st_s2[6:0];
        end else begin
            nxt_out.so  = out_ff.osh[6];
            nxt_out.osh = {out_ff.osh[5:0], 1'b0};
        end
    end

    always_ff @(negedge sck_i or negedge frm_rstn) begin
        if (!frm_rstn) begin
            out_ff <= '0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    // ---------------- system domain (mclk_i) ----------------

    // cs carries two extra stages so a frame's last byte is always seen first
    assign frame_start = sys_ff.cs_d2 & ~sys_ff.cs_d1;
    assign frame_end   = ~sys_ff.cs_d2 & sys_ff.cs_d1;
    assign byte_ev     = sys_ff.tg_s2 ^ sys_ff.tg_d;
    assign addr_prot   = snw_prot(sys_ff.addr, sys_ff.st[SNW_ST_LVL_HI:SNW_ST_LVL_LO]);

    // frame decode, write latch and status updates
    always_comb begin
        nxt_sys         = sys_ff;
        nxt_sys.cs_s1   = cs_n_i;
        nxt_sys.cs_s2   = sys_ff.cs_s1;
        nxt_sys.cs_d1   = sys_ff.cs_s2;
        nxt_sys.cs_d2   = sys_ff.cs_d1;
        nxt_sys.tg_s1   = lkx_ff.tog;
        nxt_sys.tg_s2   = sys_ff.tg_s1;
        nxt_sys.tg_d    = sys_ff.tg_s2;
        nxt_sys.wp_s1   = wp_n_i;
        nxt_sys.wp_s2   = sys_ff.wp_s1;
        nxt_sys.mem_wr  = 1'b0;
        nxt_sys.ser_wr  = 1'b0;
        nxt_sys.clk_wr  = 1'b0;
        nxt_sys.save    = 1'b0;
        nxt_sys.restore = 1'b0;
        nxt_sys.as_on   = 1'b0;
        nxt_sys.as_off  = 1'b0;
        nxt_sys.st[SNW_ST_RDY] = nv_busy_i;

        case (sys_ff.frm)
            SNW_IDLE: begin
                if (frame_start) begin
                    nxt_sys.frm   = SNW_OPC;
                    nxt_sys.idx   = SNW_IDX_OPC;
                    // guard is frozen for the frame, a late pin edge changes nothing
                    nxt_sys.guard = sys_ff.st[SNW_ST_PGEN] & ~sys_ff.wp_s2;
                end
            end
            SNW_OPC: begin
                if (byte_ev) begin
                    nxt_sys.opc = lkx_ff.hold;
                    nxt_sys.idx = SNW_IDX_B1;
                    if (lkx_ff.hold == SNW_OP_WRITE_ENABLE_CMD) begin
                        nxt_sys.st[SNW_ST_WEN] = 1'b1;
                        nxt_sys.frm            = SNW_RUN;
                    end else if (snw_gated(lkx_ff.hold) && !sys_ff.st[SNW_ST_WEN]) begin
                        nxt_sys.frm = SNW_SKIP;
                    end else begin
                        nxt_sys.frm = SNW_RUN;
                    end
                end
            end
            SNW_RUN: begin
                if (byte_ev) begin
                    if (sys_ff.idx != SNW_IDX_DATA) begin
                        nxt_sys.idx = sys_ff.idx + 2'h1;
                    end
                    case (sys_ff.opc)
                        SNW_OP_WRSTAT: begin
                            // only the first data byte counts; ready, latch, 4 and 5 kept
                            if ((sys_ff.idx == SNW_IDX_B1) && !sys_ff.guard) begin
                                nxt_sys.st = (nxt_sys.st & ~SNW_ST_WMASK) |
                                             (lkx_ff.hold & SNW_ST_WMASK);
                                nxt_sys.st[SNW_ST_LOCK] = sys_ff.st[SNW_ST_LOCK] |
                                                          lkx_ff.hold[SNW_ST_LOCK];
                            end
                        end
                        SNW_OP_MEMWR: begin
                            if (sys_ff.idx == SNW_IDX_B1) begin
                                nxt_sys.addr = {lkx_ff.hold[ADDR_W-9:0], sys_ff.addr[7:0]};
                            end else if (sys_ff.idx == SNW_IDX_B2) begin
                                nxt_sys.addr[7:0] = lkx_ff.hold;
                            end else begin
                                // address always advances and wraps, store only if open
                                nxt_sys.mem_wr   = ~addr_prot;
                                nxt_sys.mem_addr = sys_ff.addr;
                                nxt_sys.wdata    = lkx_ff.hold;
                                nxt_sys.addr     = sys_ff.addr + SNW_ADDR_ONE;
                            end
                        end
                        SNW_OP_SERWR: begin
                            nxt_sys.ser_wr = ~sys_ff.st[SNW_ST_LOCK];
                            nxt_sys.wdata  = lkx_ff.hold;
                        end
                        SNW_OP_CLKWR: begin
                            nxt_sys.clk_wr = 1'b1;
                            nxt_sys.wdata  = lkx_ff.hold;
                        end
                        default: begin
                            nxt_sys.idx = nxt_sys.idx;
                        end
                    endcase
                end
            end
            SNW_SKIP: begin
                nxt_sys.frm = SNW_SKIP;
            end
            default: begin
                nxt_sys.frm = SNW_IDLE;
            end
        endcase

        // end of frame: nonvolatile requests and latch clearing
        if (frame_end && (sys_ff.frm != SNW_IDLE)) begin
            nxt_sys.frm = SNW_IDLE;
            if (sys_ff.frm == SNW_RUN) begin
                // a save captures status_o, the only way written status persists
                nxt_sys.save    = (sys_ff.opc == SNW_OP_SAVE);
                nxt_sys.restore = (sys_ff.opc == SNW_OP_RESTR);
                nxt_sys.as_on   = (sys_ff.opc == SNW_OP_ASON);
                nxt_sys.as_off  = (sys_ff.opc == SNW_OP_ASOFF);
                if (snw_gated(sys_ff.opc)) begin
                    nxt_sys.st[SNW_ST_WEN] = 1'b0;
                end
                if (sys_ff.opc == SNW_OP_WRDIS) begin
                    nxt_sys.st[SNW_ST_WEN] = 1'b0;
                end
            end
        end
    end

    // power-up leaves status at zero and the latch cleared
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sys_ff       <= '0;
            sys_ff.cs_s1 <= 1'b1;
            sys_ff.cs_s2 <= 1'b1;
            sys_ff.cs_d1 <= 1'b1;
            sys_ff.cs_d2 <= 1'b1;
            sys_ff.wp_s1 <= 1'b1;
            sys_ff.wp_s2 <= 1'b1;
            sys_ff.frm   <= SNW_IDLE;
            sys_ff.st    <= SNW_ST_RST;
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    // outputs straight from flops
    assign so_o           = out_ff.so;
    assign so_oe_o        = out_ff.oe;
    assign status_o       = sys_ff.st;
    assign mem_wr_o       = sys_ff.mem_wr;
    assign mem_addr_o     = sys_ff.mem_addr;
    assign wr_data_o      = sys_ff.wdata;
    assign serial_wr_o    = sys_ff.ser_wr;
    assign clock_wr_o     = sys_ff.clk_wr;
    assign save_req_o     = sys_ff.save;
    assign restore_req_o  = sys_ff.restore;
    assign autosave_on_o  = sys_ff.as_on;
    assign autosave_off_o = sys_ff.as_off;

endmodule

// ### snw_status_guard_chk.sv
// assertions on the status register and write guard block
// assumes it is bound into snw_status_guard and sees only its ports
`timescale 1ns/10ps
module snw_status_guard_chk
    import snw_pkg::*;
#(
    parameter int unsigned ADDR_W = SNW_ADDR_W
) (
    input wire logic              mclk_i,
    input wire logic              rstn_i,
    input wire logic              cs_n_i,
    input wire logic              nv_busy_i,
    input wire logic [7:0]        status_o,
    input wire logic              mem_wr_o,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic              serial_wr_o,
    input wire logic              clock_wr_o,
    input wire logic              save_req_o,
    input wire logic              restore_req_o,
    input wire logic              autosave_on_o,
    input wire logic              autosave_off_o
);
    logic [3:0] idle_ff;
    logic [3:0] since_ff;
    logic       gated;
    logic       fend;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    // any accepted gated effect, and the frame end ones alone
    assign fend  = save_req_o | restore_req_o | autosave_on_o | autosave_off_o;
    assign gated = fend | mem_wr_o | serial_wr_o | clock_wr_o;

    // idle time with chip select high, and age of the last set write latch;
    // both saturate so long runs never wrap into a false pass
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            idle_ff  <= 4'h0;
            since_ff <= 4'hF;
        end else begin
            idle_ff  <= cs_n_i ? idle_ff + {3'h0, idle_ff != 4'hF} : 4'h0;
            since_ff <= status_o[1] ? 4'h0 : since_ff + {3'h0, since_ff != 4'hF};
        end
    end

    a_zero_bits: assert property (status_o[5:4] == 2'h0)
        else $error("status bits 4 and 5 not zero");
    a_ready_follow: assert property (1'b1 |=> status_o[0] == $past(nv_busy_i))
        else $error("ready flag does not follow save or restore");
    a_lock_sticky: assert property (status_o[6] |=> status_o[6])
        else $error("serial lock cleared");
    a_idle_stable: assert property (idle_ff >= 4'h8 |-> $stable(status_o[7:1]))
        else $error("status changed between frames");
    a_prot_range: assert property (mem_wr_o |-> status_o[3:2] != SNW_LVL_ALL
        && !(status_o[3:2] == SNW_LVL_QTR && mem_addr_o >= SNW_QTR_BASE)
        && !(status_o[3:2] == SNW_LVL_HALF && mem_addr_o >= SNW_HALF_BASE))
        else $error("memory write inside protected range");
    a_lock_serial: assert property (serial_wr_o |-> !status_o[6])
        else $error("serial write while locked");
    a_gated_wen: assert property (gated |-> since_ff < 4'h4)
        else $error("gated effect without write latch");
    a_wen_clears: assert property (fend |-> ##[0:3] !status_o[1])
        else $error("write latch not cleared after special");
endmodule

// ### snw_status_guard_test.sv
// self-checking bench for the status register and write guard block
// assumes snw_spi_host on the link and the checker bound below
`timescale 1ns/10ps
module snw_status_guard_test;
    import snw_pkg::*;
    logic        mclk;
    logic        rstn;
    logic        wp_n;
    logic        busy;
    wire         sck, cs_n, si, so, so_oe, so_line;
    wire  [7:0]  st;
    wire  [7:0]  wdat;
    wire  [12:0] addr;
    wire  [6:0]  pv;
    int          errors;
    int          comparisons;
    int          cnt [7];

    // device and host; so is undriven while the device is not reading
    assign so_line = so_oe ? so : 1'bz;
    snw_status_guard i_snw_status_guard (
        .mclk_i(mclk), .rstn_i(rstn), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .wp_n_i(wp_n), .nv_busy_i(busy), .so_o(so), .so_oe_o(so_oe), .status_o(st),
        .mem_wr_o(pv[0]), .mem_addr_o(addr), .wr_data_o(wdat), .serial_wr_o(pv[1]),
        .clock_wr_o(pv[2]), .save_req_o(pv[3]), .restore_req_o(pv[4]),
        .autosave_on_o(pv[5]), .autosave_off_o(pv[6]));
    snw_spi_host i_snw_spi_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so_line));

    // system clock, 100 ns
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // count every one-cycle pulse of the system side; sampled mid cycle so the
    // launching edge never races the count
    always @(negedge mclk) begin
        for (int i = 0; i < 7; i++) begin
            cnt[i] += pv[i];
        end
    end

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic send(input int nb, input logic [63:0] tx);
        logic [7:0] r;
        i_snw_spi_host.frame(nb, tx, r);
    endtask
    task automatic write_enable_cmd();
        send(1, {SNW_OP_WRITE_ENABLE_CMD, 56'h0});
    endtask
    task automatic status_write_cmd(input logic [7:0] d);
        write_enable_cmd();
        send(2, {SNW_OP_WRSTAT, d, 48'h0});
    endtask
    // third byte: plain read repeats status, fast read gives it after the dummy
    task automatic rd_chk(input logic [7:0] exp);
        logic [7:0] r;
        for (int f = 0; f < 2; f++) begin
            i_snw_spi_host.frame(3, {f ? SNW_OP_FRDST : SNW_OP_RDSTAT, 56'h0}, r);
            chk("status shifted out", r, exp);
            chk("output enable released", so_oe, 1'b0);
        end
    endtask

    task automatic t_reset;
        chk("status after reset", st, 8'h00);
        rd_chk(8'h00);
        $display("done: reset");
    endtask
    task automatic t_gate;
        send(2, {SNW_OP_WRSTAT, 8'hCC, 48'h0});
        send(4, {SNW_OP_MEMWR, 8'h00, 8'h10, 8'h5A, 32'h0});
        send(2, {SNW_OP_SERWR, 8'h11, 48'h0});
        chk("refused status", st, 8'h00);
        chk("refused writes", cnt[0] + cnt[1], 0);
        write_enable_cmd();
        chk("latch set", st, 8'h02);
        send(1, {SNW_OP_WRDIS, 56'h0});
        chk("latch cleared", st, 8'h00);
        for (int k = 0; k < 2; k++) begin
            write_enable_cmd();
            send(3, {SNW_OP_SERWR, 8'h11, 8'h22, 40'h0});
        end
        chk("serial bytes", cnt[1], 4);
        $display("done: gate");
    endtask
    task automatic t_status_write_cmd;
        status_write_cmd(8'hFF);
        chk("masked write", st, 8'hCC);
        rd_chk(8'hCC);
        status_write_cmd(8'h00);
        chk("lock kept", st, 8'h40);
        $display("done: status write");
    endtask
    task automatic t_guard;
        status_write_cmd(8'h80);
        @(negedge mclk) wp_n = 1'b0;
        status_write_cmd(8'h8C);
        chk("guarded write", st, 8'hC0);
        @(negedge mclk) wp_n = 1'b1;
        write_enable_cmd();
        fork
            send(2, {SNW_OP_WRSTAT, 8'h84, 48'h0});
            begin
                repeat (10) @(negedge mclk);
                wp_n = 1'b0;
            end
        join
        chk("pin falls mid frame", st, 8'hC4);
        @(negedge mclk) wp_n = 1'b1;
        status_write_cmd(8'h04);
        @(negedge mclk) wp_n = 1'b0;
        status_write_cmd(8'h08);
        chk("pin ignored", st, 8'h48);
        @(negedge mclk) wp_n = 1'b1;
        $display("done: guard pin");
    endtask
    task automatic t_prot;
        int ea [4] = '{2, 1, 1, 0};
        int eb [4] = '{2, 1, 0, 0};
        int c0;
        for (int lv = 0; lv < 4; lv++) begin
            status_write_cmd({4'h0, lv[1:0], 2'h0});
            chk("level", st, {4'h4, lv[1:0], 2'h0});
            c0 = cnt[0];
            write_enable_cmd();
            send(5, {SNW_OP_MEMWR, 8'h1F, 8'hFF, 8'hA1, 8'hA2, 24'h0});
            chk("wrap burst", cnt[0] - c0, ea[lv]);
            if (ea[lv] != 0) begin
                chk("wrap address", {wdat, 3'h0, addr}, 24'hA2_0000);
            end
            c0 = cnt[0];
            write_enable_cmd();
            send(5, {SNW_OP_MEMWR, 8'h17, 8'hFF, 8'hB1, 8'hB2, 24'h0});
            chk("edge burst", cnt[0] - c0, eb[lv]);
            chk("latch after write", st[1], 1'b0);
        end
        status_write_cmd(8'h00);
        $display("done: protection");
    endtask
    task automatic t_special;
        logic [7:0] ops [5] = '{SNW_OP_CLKWR, SNW_OP_SAVE, SNW_OP_RESTR, SNW_OP_ASON,
                                SNW_OP_ASOFF};
        int c0;
        for (int k = 0; k < 5; k++) begin
            c0 = cnt[k + 2];
            send(3, {ops[k], 8'h01, 8'h02, 40'h0});
            chk("refused special", cnt[k + 2] - c0, 0);
            write_enable_cmd();
            send(k == 0 ? 3 : 1, {ops[k], 8'h01, 8'h02, 40'h0});
            chk("special pulses", cnt[k + 2] - c0, k == 0 ? 2 : 1);
            chk("latch after special", st[1], 1'b0);
        end
        c0 = cnt[1];
        write_enable_cmd();
        send(2, {SNW_OP_SERWR, 8'h33, 48'h0});
        chk("locked serial", cnt[1] - c0, 0);
        $display("done: specials");
    endtask
    task automatic t_ready;
        @(negedge mclk) busy = 1'b1;
        repeat (3) @(negedge mclk);
        chk("ready busy", st[0], 1'b1);
        rd_chk(8'h41);
        @(negedge mclk) busy = 1'b0;
        repeat (3) @(negedge mclk);
        chk("ready idle", st[0], 1'b0);
        $display("done: ready");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // reset, then the scenarios in order
    initial begin
        rstn = 1'b0;
        wp_n = 1'b1;
        busy = 1'b0;
        repeat (16) @(negedge mclk);
        rstn = 1'b1;
        repeat (4) @(negedge mclk);
        t_reset();
        t_gate();
        t_status_write_cmd();
        t_guard();
        t_prot();
        t_special();
        t_ready();
        print_verdict();
    end
    // a hang counts as a mismatch
    initial begin
        #2000000;
        errors++;
        print_verdict();
    end
endmodule

bind snw_status_guard snw_status_guard_chk #(.ADDR_W(ADDR_W)) i_snw_status_guard_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .nv_busy_i(nv_busy_i),
    .status_o(status_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
    .serial_wr_o(serial_wr_o), .clock_wr_o(clock_wr_o), .save_req_o(save_req_o),
    .restore_req_o(restore_req_o), .autosave_on_o(autosave_on_o),
    .autosave_off_o(autosave_off_o));
